// [crf_pkg.sv]
// Package of the CPU register file: widths, field positions, reset values,
// operand sizes, dedicated-register selectors and the request structs.
// Assumes the core clock domain only; every user of it imports crf_pkg::*.
package crf_pkg;

  // Register widths
  localparam int unsigned HALF_W = 16;
  localparam int unsigned FULL_W = 32;
  localparam int unsigned PC_W = 24;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned NUM_GPR = 16;
  localparam int unsigned NUM_WIDE = 4;

  // Index of the first register with its own upper half
  localparam logic [3:0] FIRST_WIDE_IDX = 4'hc;
  localparam logic [3:0] LAST_SHORT_PAIR_IDX = 4'hb;
  localparam logic [3:0] RA_IDX = 4'he;
  localparam logic [3:0] R13_IDX = 4'hd;
  localparam logic [3:0] R12_IDX = 4'hc;

  // Processor status register fields
  localparam int unsigned PSR_USER_BIT = 3;
  localparam int unsigned PSR_LOCAL_IE_BIT = 9;
  localparam logic [15:0] PSR_RESET = 16'h0200;
  localparam logic [15:0] PSR_WRITE_MASK = 16'h0eef;

  // Configuration register fields
  localparam int unsigned CFG_DISPATCH_BIT = 8;
  localparam int unsigned CFG_SHORT_BIT = 9;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] CFG_WRITE_MASK = 16'h0300;

  // Interrupt stack pointer: bit 0 and the top byte hold zero
  localparam logic [31:0] ISP_KEEP_MASK = 32'h00fffffe;
  localparam logic [31:0] ADDR_LIMIT = 32'h00ffffff;
  localparam logic [31:0] WIDE_RESET = 32'h00000000;
  localparam logic [15:0] HALF_RESET = 16'h0000;

  // Width of a general-purpose operand
  typedef enum logic [1:0] {
    CRF_SIZE_BYTE = 2'b00,
    CRF_SIZE_WORD = 2'b01,
    CRF_SIZE_DWORD = 2'b11
  } crf_size_type;

  // Dedicated registers reached through the side port
  typedef enum logic [2:0] {
    CRF_DR_PSR = 3'h0,
    CRF_DR_CFG = 3'h1,
    CRF_DR_ISP = 3'h2,
    CRF_DR_USP = 3'h3,
    CRF_DR_BASE = 3'h4,
    CRF_DR_PC = 3'h5
  } crf_dreg_type;

  typedef struct packed {
    logic [3:0] idx;
    crf_size_type size;
  } crf_rd_req_type;

  typedef struct packed {
    logic en;
    logic [3:0] idx;
    crf_size_type size;
    logic [31:0] data;
  } crf_wr_req_type;

  typedef struct packed {
    logic en;
    crf_dreg_type sel;
    logic [31:0] data;
  } crf_dr_wr_type;

  // Where a 32-bit operand lives: its own upper half, or two low halves
  typedef struct packed {
    logic wide;
    logic [3:0] lo_idx;
  } crf_pair_type;

  function automatic crf_pair_type crf_pair_split(input logic [3:0] idx, input logic short_mode);
    crf_pair_type p;
    p.wide = 1'b0;
    p.lo_idx = idx;
    if (idx > LAST_SHORT_PAIR_IDX) begin
      if (short_mode && idx == RA_IDX) begin
        p.lo_idx = R13_IDX; // RQ8
      end else if (!short_mode || idx > RA_IDX) begin
        p.wide = 1'b1;
      end
    end
    return p;
  endfunction

endpackage

// [crf_operand_mux.sv]
// Read multiplexer: forms one operand of the asked size from the register halves.
// Assumes the halves are current register outputs; purely combinational.
`timescale 1ns/1ns
module crf_operand_mux (
  input wire logic [15:0][15:0] lo_q,
  input wire logic [3:0][15:0] hi_q,
  input wire logic short_mode,
  input wire crf_pkg::crf_rd_req_type req,
  output logic [31:0] operand
);
  import crf_pkg::*;

  crf_pair_type pair;
  logic [3:0] up_idx;

  assign pair = crf_pair_split(req.idx, short_mode);
  assign up_idx = pair.lo_idx + 4'h1;

  // Narrow sizes never look above the low byte or word
  always_comb begin
    unique case (req.size)
      CRF_SIZE_BYTE: operand = {24'h000000, lo_q[req.idx][7:0]}; // RQ10
      CRF_SIZE_WORD: operand = {16'h0000, lo_q[req.idx]}; // RQ11
      CRF_SIZE_DWORD: begin
        if (pair.wide) begin
          operand = {hi_q[req.idx[1:0]], lo_q[req.idx]}; // RQ9
        end else begin
          operand = {lo_q[up_idx], lo_q[pair.lo_idx]}; // RQ7
        end
      end
      default: operand = 32'h00000000;
    endcase
  end
endmodule

// [crf_write_decode.sv]
// Write decoder: turns one write request into byte-lane enables per half.
// Assumes one write per cycle; the register process applies all lanes at once.
`timescale 1ns/1ns
module crf_write_decode (
  input wire crf_pkg::crf_wr_req_type req,
  input wire logic short_mode,
  output logic [15:0][1:0] lo_lane,
  output logic [15:0][15:0] lo_data,
  output logic [3:0] hi_en,
  output logic [15:0] hi_data
);
  import crf_pkg::*;

  crf_pair_type pair;
  logic [3:0] up_idx;

  assign pair = crf_pair_split(req.idx, short_mode);
  assign up_idx = pair.lo_idx + 4'h1;
  assign hi_data = req.data[31:16];

  // Both halves of a pair are enabled in the one cycle of the request
  always_comb begin
    lo_lane = '0;
    lo_data = '0;
    hi_en = 4'h0;
    if (req.en) begin
      unique case (req.size)
        CRF_SIZE_BYTE: begin
          lo_lane[req.idx] = 2'b01; // RQ10
          lo_data[req.idx] = {8'h00, req.data[7:0]};
        end
        CRF_SIZE_WORD: begin
          lo_lane[req.idx] = 2'b11; // RQ11
          lo_data[req.idx] = req.data[15:0];
        end
        CRF_SIZE_DWORD: begin
          lo_lane[pair.lo_idx] = 2'b11; // RQ17
          lo_data[pair.lo_idx] = req.data[15:0];
          if (pair.wide) begin
            hi_en[req.idx[1:0]] = 1'b1; // RQ9
          end else begin
            lo_lane[up_idx] = 2'b11; // RQ7
            lo_data[up_idx] = req.data[31:16];
          end
        end
        default: begin
          lo_lane = '0;
        end
      endcase
    end
  end
endmodule

// [crf_register_file.sv]
// Register file of the 16-bit RISC core: general registers, address registers,
// status and configuration, with pairing, narrow access and warm reset.
// Assumes decode/execute logic on sys_clk drives the requests synchronously.
//
// Operation
// RQ1: R0 to R11, status and configuration registers are sixteen bits wide.
// RQ2: R12, R13, return address, stack pointers are thirty-two bits wide.
// RQ3: Program counter is 24 bits, addressing the current instruction's first byte.
// RQ4: Sixteen general registers, used alone or paired into wider operands.
// RQ5: Reserved bits read with no defined content.
// RQ6: Software writes zero to every reserved bit.
// RQ7: Short mode pairs adjacent low halves up to the stack pointer.
// RQ8: Short mode pair of R14 and R13 lows equals extended return address.
// RQ9: Native mode pairs up to R11; upper registers act as single wide.
// RQ10: Byte operations touch only the lowest byte of a register.
// RQ11: Word operations on pairs touch only the lower word.
// RQ12: Program counter bit zero always holds zero.
// RQ13: Reset loads the program counter with zero or a chosen start.
// RQ14: Warm reset copies the earlier program counter into R1 and R0.
// RQ15: Reset clears every configuration bit, selecting native wide pairing.
// RQ16: Interrupt stack pointer bit zero and top eight bits read zero.
// RQ17: A wide pair write updates both halves in the same cycle.
`timescale 1ns/1ns
module crf_register_file #(
  parameter logic [23:0] START_PC = 24'h000000
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic warm_reset,
  input wire crf_pkg::crf_rd_req_type rd_a_req,
  input wire crf_pkg::crf_rd_req_type rd_b_req,
  output logic [31:0] rd_a_data,
  output logic [31:0] rd_b_data,
  input wire crf_pkg::crf_wr_req_type wr_req,
  input wire crf_pkg::crf_dr_wr_type dr_wr,
  input wire crf_pkg::crf_dreg_type dr_rd_sel,
  output logic [31:0] dr_rd_data,
  input wire logic pc_load,
  input wire logic [23:0] pc_next,
  output logic [23:0] program_counter,
  output logic short_register_mode,
  output logic extended_dispatch,
  output logic user_mode,
  output logic [31:0] active_stack_pointer,
  output logic user_stack_illegal
);
  import crf_pkg::*;

  // Low halves of all sixteen registers, upper halves of R12, R13, RA, SP
  logic [15:0][15:0] lo_q;
  logic [3:0][15:0] hi_q;

  // Dedicated and control registers
  logic [15:0] processor_status_register;
  logic [15:0] configuration_register;
  logic [31:0] interrupt_stack_pointer;
  logic [31:0] user_stack_pointer;
  logic [31:0] dispatch_table_base;

  // Decoded write lanes, operand mux outputs and next values
  logic [15:0][1:0] lo_lane;
  logic [15:0][15:0] lo_data;
  logic [3:0] hi_en;
  logic [15:0] hi_data;
  logic [31:0] next_rd_a;
  logic [31:0] next_rd_b;
  logic [31:0] next_dr_rd;
  logic [31:0] stack_pointer;
  logic [31:0] warm_pair;
  logic [15:0] next_processor_status_register;
  logic [15:0] next_configuration_register;
  logic [31:0] next_interrupt_stack_pointer;
  logic [23:0] next_program_counter;

  assign short_register_mode = configuration_register[CFG_SHORT_BIT];
  assign extended_dispatch = configuration_register[CFG_DISPATCH_BIT];
  assign user_mode = processor_status_register[PSR_USER_BIT];
  assign stack_pointer = {hi_q[3], lo_q[15]};

  // Old program counter, zero-extended, as the value landing in R1:R0
  assign warm_pair = {8'h00, program_counter};

  // Decode of the single general-register write port
  crf_write_decode u_write_decode (
    .req(wr_req),
    .short_mode(short_register_mode),
    .lo_lane(lo_lane),
    .lo_data(lo_data),
    .hi_en(hi_en),
    .hi_data(hi_data)
  );

  // Two read ports share the same pairing rules as the write port
  crf_operand_mux u_mux_a (
    .lo_q(lo_q),
    .hi_q(hi_q),
    .short_mode(short_register_mode),
    .req(rd_a_req),
    .operand(next_rd_a)
  );

  crf_operand_mux u_mux_b (
    .lo_q(lo_q),
    .hi_q(hi_q),
    .short_mode(short_register_mode),
    .req(rd_b_req),
    .operand(next_rd_b)
  );

  // Low halves: one flop group per register; byte lanes make narrow writes safe
  // Warm reset wins over a write to R0, R1 or R2 in the same cycle so the saved state is exact
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GPR; gi++) begin : g_lo
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          lo_q[gi] <= HALF_RESET;
        end else if (warm_reset && gi == 0) begin
          lo_q[gi] <= warm_pair[15:0]; // RQ14
        end else if (warm_reset && gi == 1) begin
          lo_q[gi] <= warm_pair[31:16]; // RQ14
        end else if (warm_reset && gi == 2) begin
          lo_q[gi] <= processor_status_register;
        end else begin
          if (lo_lane[gi][0]) begin
            lo_q[gi][7:0] <= lo_data[gi][7:0]; // RQ10
          end
          if (lo_lane[gi][1]) begin
            lo_q[gi][15:8] <= lo_data[gi][15:8]; // RQ11
          end
        end
      end
    end
  endgenerate

  // Upper halves exist only for the four wide registers
  generate
    for (gi = 0; gi < NUM_WIDE; gi++) begin : g_hi
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          hi_q[gi] <= HALF_RESET;
        end else if (hi_en[gi]) begin
          hi_q[gi] <= hi_data; // RQ2
        end
      end
    end
  endgenerate

  // Next status: warm reset restores the power-up value after R2 has taken a copy
  always_comb begin
    next_processor_status_register = processor_status_register;
    if (warm_reset) begin
      next_processor_status_register = PSR_RESET;
    end else if (dr_wr.en && dr_wr.sel == CRF_DR_PSR) begin
      next_processor_status_register = dr_wr.data[15:0] & PSR_WRITE_MASK; // RQ1
    end
  end

  // Status register flop: constant-zero and reserved bits are never stored
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      processor_status_register <= PSR_RESET;
    end else begin
      processor_status_register <= next_processor_status_register;
    end
  end

  // Next configuration: warm reset drops back to native pairing at once
  always_comb begin
    next_configuration_register = configuration_register;
    if (warm_reset) begin
      next_configuration_register = CFG_RESET; // RQ15
    end else if (dr_wr.en && dr_wr.sel == CRF_DR_CFG) begin
      next_configuration_register = dr_wr.data[15:0] & CFG_WRITE_MASK; // RQ1
    end
  end

  // Configuration flop: only the dispatch and short-register bits are kept
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      configuration_register <= CFG_RESET; // RQ15
    end else begin
      configuration_register <= next_configuration_register;
    end
  end

  // Next interrupt stack pointer: the forced-zero bits are masked on every write,
  // so the stored value already reads correctly on any path
  always_comb begin
    next_interrupt_stack_pointer = interrupt_stack_pointer;
    if (dr_wr.en && dr_wr.sel == CRF_DR_ISP) begin
      next_interrupt_stack_pointer = dr_wr.data & ISP_KEEP_MASK; // RQ16
    end
  end

  // Interrupt stack pointer flop; warm reset leaves it alone
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_stack_pointer <= WIDE_RESET;
    end else begin
      interrupt_stack_pointer <= next_interrupt_stack_pointer;
    end
  end

  // User stack pointer keeps all 32 bits; an out-of-range value is flagged
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      user_stack_pointer <= WIDE_RESET;
    end else if (dr_wr.en && dr_wr.sel == CRF_DR_USP) begin
      user_stack_pointer <= dr_wr.data; // RQ2
    end
  end

  // Dispatch base stored as written; software keeps its reserved bits zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dispatch_table_base <= WIDE_RESET;
    end else if (dr_wr.en && dr_wr.sel == CRF_DR_BASE) begin
      dispatch_table_base <= dr_wr.data; // RQ6
    end
  end

  // Next program counter: warm reset first, then a jump, then a side-port write.
  // A jump beats a side write in the same cycle since it is the live instruction flow
  always_comb begin
    next_program_counter = program_counter;
    if (warm_reset) begin
      next_program_counter = {START_PC[23:1], 1'b0}; // RQ13
    end else if (pc_load) begin
      next_program_counter = {pc_next[23:1], 1'b0}; // RQ12
    end else if (dr_wr.en && dr_wr.sel == CRF_DR_PC) begin
      next_program_counter = {dr_wr.data[23:1], 1'b0}; // RQ3
    end
  end

  // Program counter flop: bit 0 is dropped upstream so an odd target cannot be held
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      program_counter <= {START_PC[23:1], 1'b0}; // RQ13
    end else begin
      program_counter <= next_program_counter;
    end
  end

  // Side-port read mux; undefined bits are simply returned as zero
  always_comb begin
    next_dr_rd = 32'h00000000;
    unique case (dr_rd_sel)
      CRF_DR_PSR: next_dr_rd = {16'h0000, processor_status_register}; // RQ5
      CRF_DR_CFG: next_dr_rd = {16'h0000, configuration_register}; // RQ5
      CRF_DR_ISP: next_dr_rd = interrupt_stack_pointer & ISP_KEEP_MASK; // RQ16
      CRF_DR_USP: next_dr_rd = user_stack_pointer;
      CRF_DR_BASE: next_dr_rd = dispatch_table_base;
      CRF_DR_PC: next_dr_rd = {8'h00, program_counter}; // RQ3
      default: next_dr_rd = 32'h00000000;
    endcase
  end

  // Operand reads are registered: data arrives one cycle after the request
  // and shows the contents before any write in the request cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_a_data <= WIDE_RESET;
    end else begin
      rd_a_data <= next_rd_a; // RQ4
    end
  end

  // Second port is independent, so both operands of one instruction come together
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_b_data <= WIDE_RESET;
    end else begin
      rd_b_data <= next_rd_b; // RQ4
    end
  end

  // Side-port read data, one cycle after the select
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dr_rd_data <= WIDE_RESET;
    end else begin
      dr_rd_data <= next_dr_rd;
    end
  end

  // Stack in use follows the user bit; registered to keep outputs on flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      active_stack_pointer <= WIDE_RESET;
    end else begin
      active_stack_pointer <= user_mode ? user_stack_pointer : stack_pointer; // RQ2
    end
  end

  // Range flag for the user stack; the trap itself is taken by the execute logic
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      user_stack_illegal <= 1'b0;
    end else begin
      user_stack_illegal <= user_stack_pointer > ADDR_LIMIT;
    end
  end

endmodule

// [crf_asserts.sv]
// Port checker for the register file: pc, configuration and operand shapes.
// Assumes one clock domain, sys_clk, with rst_b as asynchronous active-low reset.
`timescale 1ns/1ns
module crf_asserts #(
  parameter logic [23:0] START_PC = 24'h000000
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic warm_reset,
  input wire crf_pkg::crf_rd_req_type rd_a_req,
  input wire crf_pkg::crf_rd_req_type rd_b_req,
  input wire logic [31:0] rd_a_data,
  input wire logic [31:0] rd_b_data,
  input wire crf_pkg::crf_dr_wr_type dr_wr,
  input wire crf_pkg::crf_dreg_type dr_rd_sel,
  input wire logic [31:0] dr_rd_data,
  input wire logic pc_load,
  input wire logic [23:0] pc_next,
  input wire logic [23:0] program_counter,
  input wire logic short_register_mode
);
  import crf_pkg::*;
  // Everything samples on the core clock and sleeps through reset
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  pc_even_a: assert property (
    program_counter[0] == 1'b0) else $error("pc bit zero set");
  pc_load_a: assert property (
    pc_load && !warm_reset |=> program_counter == ($past(pc_next) & 24'hfffffe)) else $error("pc load wrong");
  // A pc that moves with no cause would lose the current instruction
  pc_hold_a: assert property (
    !pc_load && !warm_reset && !(dr_wr.en && dr_wr.sel == CRF_DR_PC) |=> $stable(program_counter))
    else $error("pc moved alone");
  warm_pc_a: assert property (
    warm_reset |=> program_counter == (START_PC & 24'hfffffe)) else $error("warm pc wrong");
  cfg_set_a: assert property (
    dr_wr.en && dr_wr.sel == CRF_DR_CFG && !warm_reset |=> short_register_mode == $past(dr_wr.data[9]))
    else $error("short mode not loaded");
  warm_cfg_a: assert property (
    warm_reset |=> !short_register_mode) else $error("short mode kept");
  isp_mask_a: assert property (
    dr_rd_sel == CRF_DR_ISP |=> (dr_rd_data & ~ISP_KEEP_MASK) == 32'h00000000) else $error("isp bits set");
  rd_byte_a: assert property (
    rd_a_req.size == CRF_SIZE_BYTE |=> rd_a_data[31:8] == 24'h000000) else $error("byte read wide");
  rd_word_a: assert property (
    rd_a_req.size == CRF_SIZE_WORD |=> rd_a_data[31:16] == 16'h0000) else $error("word read wide");
  rd_bad_a: assert property (
    rd_b_req.size == crf_size_type'(2'b10) |=> rd_b_data == 32'h00000000) else $error("bad size data");
endmodule
bind crf_register_file crf_asserts #(.START_PC(START_PC)) u_asserts (
  .sys_clk(sys_clk), .rst_b(rst_b), .warm_reset(warm_reset), .rd_a_req(rd_a_req), .rd_b_req(rd_b_req),
  .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .dr_wr(dr_wr), .dr_rd_sel(dr_rd_sel),
  .dr_rd_data(dr_rd_data), .pc_load(pc_load), .pc_next(pc_next), .program_counter(program_counter),
  .short_register_mode(short_register_mode));

// [crf_cpu_model.sv]
// Behavioural decode/execute model that issues register file requests.
// Assumes sys_clk is the core clock; requests change only at falling edges.
`timescale 1ns/1ns
module crf_cpu_model (
  input wire logic sys_clk,
  output logic warm_reset,
  output crf_pkg::crf_rd_req_type rd_a_req,
  output crf_pkg::crf_rd_req_type rd_b_req,
  input wire logic [31:0] rd_a_data,
  output crf_pkg::crf_wr_req_type wr_req,
  output crf_pkg::crf_dr_wr_type dr_wr,
  output crf_pkg::crf_dreg_type dr_rd_sel,
  input wire logic [31:0] dr_rd_data,
  output logic pc_load,
  output logic [23:0] pc_next
);
  import crf_pkg::*;
  // Idle requests at time zero
  initial begin
    warm_reset = 1'b0;
    rd_a_req = '{4'h0, CRF_SIZE_WORD};
    rd_b_req = '{4'h0, CRF_SIZE_WORD};
    wr_req = '{1'b0, 4'h0, CRF_SIZE_WORD, 32'h0};
    dr_wr = '{1'b0, CRF_DR_PSR, 32'h0};
    dr_rd_sel = CRF_DR_PSR;
    pc_load = 1'b0;
    pc_next = 24'h0;
  end
  // Released data is inverted so a stale value cannot pass for a held one
  task automatic wr(input logic [3:0] idx, input crf_size_type size, input logic [31:0] data);
    @(negedge sys_clk);
    wr_req = '{1'b1, idx, size, data};
    @(negedge sys_clk);
    wr_req = '{1'b0, ~idx, size, ~data};
  endtask
  // Configuration writes carry zero in every reserved bit
  task automatic dwr(input crf_dreg_type sel, input logic [31:0] data);
    @(negedge sys_clk);
    dr_wr = '{1'b1, sel, (sel == CRF_DR_CFG) ? (data & {16'h0000, CFG_WRITE_MASK}) : data};
    @(negedge sys_clk);
    dr_wr = '{1'b0, sel, ~data};
  endtask
  // Port b always asks for the illegal size alongside port a
  task automatic rd(input logic [3:0] idx, input crf_size_type size, output logic [31:0] data);
    @(negedge sys_clk);
    rd_a_req = '{idx, size};
    rd_b_req = '{idx, crf_size_type'(2'b10)};
    @(negedge sys_clk);
    data = rd_a_data;
  endtask
  task automatic drd(input crf_dreg_type sel, output logic [31:0] data);
    @(negedge sys_clk);
    dr_rd_sel = sel;
    @(negedge sys_clk);
    data = dr_rd_data;
  endtask
  task automatic pcl(input logic [23:0] v);
    @(negedge sys_clk);
    pc_load = 1'b1;
    pc_next = v;
    @(negedge sys_clk);
    pc_load = 1'b0;
    pc_next = ~v;
  endtask
  task automatic warm();
    @(negedge sys_clk);
    warm_reset = 1'b1;
    @(negedge sys_clk);
    warm_reset = 1'b0;
  endtask
endmodule

// [testbench.sv]
// Self-checking bench for the register file, driven through the cpu model.
// Assumes a 125 MHz core clock and an odd start pc to show bit zero masking.
`timescale 1ns/1ns
module testbench;
  import crf_pkg::*;
  localparam logic [23:0] START = 24'h000125;
  logic sys_clk, rst_b, warm_reset, pc_load, short_register_mode, extended_dispatch, user_mode, user_stack_illegal;
  crf_rd_req_type rd_a_req, rd_b_req;
  crf_wr_req_type wr_req;
  crf_dr_wr_type dr_wr;
  crf_dreg_type dr_rd_sel;
  logic [31:0] rd_a_data, rd_b_data, dr_rd_data, active_stack_pointer, v;
  logic [23:0] pc_next, program_counter;
  int fail_count, n_compared;
  crf_register_file #(.START_PC(START)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .warm_reset(warm_reset),
    .rd_a_req(rd_a_req), .rd_b_req(rd_b_req), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data),
    .wr_req(wr_req), .dr_wr(dr_wr), .dr_rd_sel(dr_rd_sel), .dr_rd_data(dr_rd_data), .pc_load(pc_load),
    .pc_next(pc_next), .program_counter(program_counter), .short_register_mode(short_register_mode),
    .extended_dispatch(extended_dispatch), .user_mode(user_mode), .active_stack_pointer(active_stack_pointer),
    .user_stack_illegal(user_stack_illegal));
  crf_cpu_model cpu (.sys_clk(sys_clk), .warm_reset(warm_reset), .rd_a_req(rd_a_req), .rd_b_req(rd_b_req),
    .rd_a_data(rd_a_data), .wr_req(wr_req), .dr_wr(dr_wr), .dr_rd_sel(dr_rd_sel),
    .dr_rd_data(dr_rd_data), .pc_load(pc_load), .pc_next(pc_next));
  // 8 ns core clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    check({8'h00, program_counter}, 32'h000124);
    cpu.drd(CRF_DR_CFG, v);
    check(v, 32'h0);
  endtask
  // Native pairs: low registers pair upward, R12 stands alone at 32 bits
  task automatic t_native();
    cpu.wr(4'h3, CRF_SIZE_DWORD, 32'h89abcdef);
    cpu.rd(4'h4, CRF_SIZE_WORD, v);
    check(v, 32'h000089ab);
    cpu.rd(4'h3, CRF_SIZE_DWORD, v);
    check(v, 32'h89abcdef);
    cpu.wr(4'hc, CRF_SIZE_DWORD, 32'h12345678);
    cpu.rd(4'hc, CRF_SIZE_DWORD, v);
    check(v, 32'h12345678);
    cpu.rd(4'hb, CRF_SIZE_DWORD, v);
    check(v, 32'h56780000);
  endtask
  // Narrow writes must leave the upper parts alone
  task automatic t_narrow();
    cpu.wr(4'h5, CRF_SIZE_WORD, 32'hffff1234);
    cpu.wr(4'h5, CRF_SIZE_BYTE, 32'hffffff5c);
    cpu.rd(4'h5, CRF_SIZE_DWORD, v);
    check(v, 32'h0000125c);
    cpu.wr(4'hc, CRF_SIZE_WORD, 32'hffffaaaa);
    cpu.rd(4'hc, CRF_SIZE_DWORD, v);
    check(v, 32'h1234aaaa);
  endtask
  task automatic t_short();
    cpu.dwr(CRF_DR_CFG, 32'h00000200);
    check({31'h0, short_register_mode}, 32'h1);
    cpu.wr(4'hd, CRF_SIZE_DWORD, 32'hbeefcafe);
    cpu.rd(4'he, CRF_SIZE_DWORD, v);
    check(v, 32'hbeefcafe);
    cpu.rd(4'hc, CRF_SIZE_DWORD, v);
    check(v, 32'hcafeaaaa);
    cpu.dwr(CRF_DR_CFG, 32'h0);
    cpu.rd(4'hd, CRF_SIZE_DWORD, v);
    check(v, 32'h0000cafe);
  endtask
  task automatic t_dedicated();
    cpu.dwr(CRF_DR_ISP, 32'hffffffff);
    cpu.drd(CRF_DR_ISP, v);
    check(v, 32'h00fffffe);
    cpu.dwr(CRF_DR_PC, 32'h00003457);
    check({8'h00, program_counter}, 32'h00003456);
    cpu.drd(CRF_DR_PC, v);
    check(v, 32'h00003456);
    cpu.dwr(CRF_DR_BASE, 32'h00123456);
    cpu.drd(CRF_DR_BASE, v);
    check(v, 32'h00123456);
  endtask
  // Status bits, user stack choice, range flag at its limit, dispatch size bit
  task automatic t_status();
    cpu.dwr(CRF_DR_USP, 32'h01000000);
    cpu.dwr(CRF_DR_PSR, 32'h00000fff);
    cpu.drd(CRF_DR_PSR, v);
    check(v, {16'h0000, PSR_WRITE_MASK});
    check({31'h0, user_mode}, 32'h1);
    check(active_stack_pointer, 32'h01000000);
    check({31'h0, user_stack_illegal}, 32'h1);
    cpu.dwr(CRF_DR_USP, 32'h00ffffff);
    cpu.drd(CRF_DR_USP, v);
    check(v, 32'h00ffffff);
    check({31'h0, user_stack_illegal}, 32'h0);
    cpu.dwr(CRF_DR_CFG, 32'h00000100);
    check({31'h0, extended_dispatch}, 32'h1);
    cpu.drd(CRF_DR_CFG, v);
    check(v, 32'h00000100);
  endtask
  // Warm reset saves the old pc and drops back to native pairing
  task automatic t_warm();
    cpu.pcl(24'h345678);
    cpu.dwr(CRF_DR_CFG, 32'h00000200);
    cpu.warm();
    check({8'h00, program_counter}, 32'h000124);
    check({31'h0, short_register_mode}, 32'h0);
    cpu.rd(4'h0, CRF_SIZE_DWORD, v);
    check(v, 32'h00345678);
    cpu.rd(4'h2, CRF_SIZE_WORD, v);
    check(v, {16'h0000, PSR_WRITE_MASK});
    cpu.drd(CRF_DR_PSR, v);
    check(v, {16'h0000, PSR_RESET});
    check({31'h0, extended_dispatch}, 32'h0);
    check(active_stack_pointer, 32'h0);
  endtask
  // Main sequence: reset for ten cycles, then each scenario in turn
  initial begin
    fail_count = 0;
    n_compared = 0;
    rst_b = 1'b0;
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    t_reset();
    t_native();
    t_narrow();
    t_short();
    t_dedicated();
    t_status();
    t_warm();
    complete_run();
  end
  // The scenarios need well under a thousand cycles
  initial begin
    #20000;
    fail_count++;
    complete_run();
  end
endmodule
